// File: hw/fcsr_pkg.sv
package fcsr_pkg;
  // bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // register byte offsets
  localparam logic [7:0] OFF_TAPE = 8'h00;
  localparam logic [7:0] OFF_MAIN = 8'h04;
  localparam logic [7:0] OFF_RATE_SEL = 8'h08;
  localparam logic [7:0] OFF_RATE_CTL = 8'h0c;
  localparam logic [7:0] OFF_DRV_OUT = 8'h10;
  localparam logic [7:0] OFF_CFG = 8'h14;
  localparam logic [7:0] OFF_DRV_ID = 8'h18;
  localparam logic [7:0] OFF_PCMP_TRK = 8'h1c;

  // reset values
  localparam logic [7:0] RATE_SEL_RST = 8'h02;
  localparam logic [7:0] DRV_OUT_RST = 8'h00;
  localparam logic [3:0] TAPE_RST = 4'h0;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [7:0] DRV_ID_RST = 8'h00;
  localparam logic [7:0] PCMP_TRK_RST = 8'h00;
  localparam logic [7:0] MAIN_NOT_READY = 8'h00;

  // field positions
  localparam int CFG_ENH_BIT = 6;
  localparam int CFG_FOUR_BIT = 7;
  localparam int DOR_NRST_BIT = 2;
  localparam int DOR_DMA_BIT = 3;
  localparam int DOR_MOTOR_LSB = 4;
  localparam logic [1:0] TAPE_RSVD = 2'h3;

  // drive exchange codes
  localparam logic [1:0] XCHG_NONE = 2'h0;
  localparam logic [1:0] XCHG_01 = 2'h1;
  localparam logic [1:0] XCHG_02 = 2'h2;

  // data rate codes
  localparam logic [1:0] RATE_500K = 2'h0;
  localparam logic [1:0] RATE_300K = 2'h1;
  localparam logic [1:0] RATE_250K = 2'h2;
  localparam logic [1:0] RATE_1M = 2'h3;

  // precompensation codes and step counts (one step is 41.67 ns)
  localparam logic [2:0] PCMP_DEFAULT = 3'h0;
  localparam logic [2:0] PCMP_ZERO = 3'h7;
  localparam logic [2:0] PCMP_DEF_FAST = 3'h1;
  localparam logic [2:0] PCMP_DEF_SLOW = 3'h3;
  localparam logic [2:0] PCMP_NONE = 3'h0;

  // time to ready after reset, rounded down to whole cycles
  localparam int CLK_PERIOD_NS = 25;
  localparam int READY_TIME_NS = 2500000;
  localparam int READY_CYCLES = READY_TIME_NS / CLK_PERIOD_NS;
endpackage : fcsr_pkg

// File: hw/fcsr_regs.sv
// How it works
// - tape select 00 none, else drives 1-3
// - compatible mode hides tape bits 7..2
// - config bit 6 picks compatible/enhanced mode
// - exchange bits swap drive 0 with 1/2
// - no drive 3 swap; four-drive disables exchange
// - tape bits 5..4 show selected drive ID
// - tape bits 7..6 read as 11
// - status reads 00h until initialised
// - status reads 80h within 2.5 ms
// - drive busy set on seek, cleared on sense
// - command-in-progress spans first write to last read, or to last write if no result
// - non-DMA execution bit follows engine phase
// - direction bit shows host read or write
// - request-for-master clears per byte, resets low
// - rate-select write-only; last rate write wins
// - hardware reset loads 02h; soft reset keeps
// - rate codes 500k, 300k, 250k, 1M
// - precomp codes step 41.67 ns, 111 zero
// - default precomp 41.7 ns at 1M, else 125
// - precomp start track resets to 0
// - drive select activates exactly one drive
//
// The register offsets and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ps
module fcsr_regs #(
  parameter int unsigned READY_CYCLES = fcsr_pkg::READY_CYCLES
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // axi4-lite write address and data
  input wire logic [fcsr_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [fcsr_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [fcsr_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [fcsr_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // command engine events, one-cycle pulses
  input wire logic cmd_first_wr,
  input wire logic cmd_last_wr,
  input wire logic cmd_no_result,
  input wire logic result_last_rd,
  input wire logic seek_issue,
  input wire logic [1:0] seek_drive,
  input wire logic sense_first_rd,
  input wire logic [1:0] sense_drive,
  input wire logic byte_xfer,
  input wire logic ready_next,
  // command engine levels
  input wire logic exec_nondma,
  input wire logic dir_to_host,
  input wire logic int_status,
  input wire logic power_down,
  // drive and rate outputs
  output logic [3:0] drive_sel,
  output logic [3:0] motor_en,
  output logic dma_en,
  output logic ctl_reset,
  output logic [1:0] data_rate,
  output logic [2:0] precomp_steps,
  output logic [7:0] precomp_track,
  output logic [1:0] tape_drive
);

  // logical to physical drive mapping under an exchange code
  function automatic logic [1:0] fcsr_map(input logic [1:0] d, input logic [1:0] x);
    logic [1:0] m;
    m = d;
    if (x == fcsr_pkg::XCHG_01) begin
      if (d == 2'h0) m = 2'h1;
      else if (d == 2'h1) m = 2'h0;
    end else if (x == fcsr_pkg::XCHG_02) begin
      if (d == 2'h0) m = 2'h2;
      else if (d == 2'h2) m = 2'h0;
    end
    return m;
  endfunction : fcsr_map

  // address decode shared by read and write
  function automatic logic fcsr_hit(input logic [fcsr_pkg::ADDR_W-1:0] a);
    return (a == fcsr_pkg::OFF_TAPE) || (a == fcsr_pkg::OFF_MAIN) ||
           (a == fcsr_pkg::OFF_RATE_SEL) || (a == fcsr_pkg::OFF_RATE_CTL) ||
           (a == fcsr_pkg::OFF_DRV_OUT) || (a == fcsr_pkg::OFF_CFG) ||
           (a == fcsr_pkg::OFF_DRV_ID) || (a == fcsr_pkg::OFF_PCMP_TRK);
  endfunction : fcsr_hit

  localparam int CNT_W = $clog2(READY_CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(READY_CYCLES - 1);

  // bus-side state
  logic aw_held_r;
  logic [fcsr_pkg::ADDR_W-1:0] aw_addr_r;
  logic w_held_r;
  logic [7:0] w_data_r;
  logic w_lane0_r;
  logic awready_r;
  logic wready_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic arready_r;
  logic rvalid_r;
  logic [fcsr_pkg::DATA_W-1:0] rdata_r;
  logic [1:0] rresp_r;

  // software registers
  logic [3:0] tape_r;          // exchange and tape select
  logic [7:0] rate_sel_r;      // write-only rate and precomp byte
  logic [1:0] rate_act_r;      // rate from the latest rate write
  logic [7:0] dor_r;           // drive output control
  logic [7:0] cfg_r;           // mode and four-drive bits
  logic [7:0] drv_id_r;        // two-bit id per drive
  logic [7:0] pcmp_trk_r;      // precomp start track

  // status state
  logic [CNT_W-1:0] init_cnt_r;
  logic ready_r;
  logic [3:0] busy_r;
  logic cip_r;
  logic rqm_r;

  // output flops
  logic [3:0] drive_sel_r;
  logic [3:0] motor_r;
  logic dma_en_r;
  logic ctl_reset_r;
  logic [2:0] pcmp_steps_r;

  // handshake terms
  wire take_aw = s_axi_awvalid & awready_r;
  wire take_w = s_axi_wvalid & wready_r;
  wire do_wr = aw_held_r & w_held_r & ~bvalid_r;
  wire take_ar = s_axi_arvalid & arready_r;
  wire aw_held_nxt = take_aw | (aw_held_r & ~do_wr);
  wire w_held_nxt = take_w | (w_held_r & ~do_wr);
  wire bvalid_nxt = do_wr | (bvalid_r & ~s_axi_bready);
  wire rvalid_nxt = take_ar | (rvalid_r & ~s_axi_rready);

  // write strobes per register, low byte lane only
  wire wr_ok = do_wr & w_lane0_r;
  wire wr_tape = wr_ok & (aw_addr_r == fcsr_pkg::OFF_TAPE);
  wire wr_rate_sel = wr_ok & (aw_addr_r == fcsr_pkg::OFF_RATE_SEL);
  wire wr_rate_ctl = wr_ok & (aw_addr_r == fcsr_pkg::OFF_RATE_CTL);
  wire wr_dor = wr_ok & (aw_addr_r == fcsr_pkg::OFF_DRV_OUT);
  wire wr_cfg = wr_ok & (aw_addr_r == fcsr_pkg::OFF_CFG);
  wire wr_drv_id = wr_ok & (aw_addr_r == fcsr_pkg::OFF_DRV_ID);
  wire wr_pcmp_trk = wr_ok & (aw_addr_r == fcsr_pkg::OFF_PCMP_TRK);

  // mode decode
  wire enh_mode = cfg_r[fcsr_pkg::CFG_ENH_BIT];
  wire four_drive = cfg_r[fcsr_pkg::CFG_FOUR_BIT];
  // exchange only in enhanced mode and never with four drives; 11 acts as none
  wire [1:0] xchg_eff = (enh_mode && !four_drive && tape_r[3:2] != 2'h3) ?
                        tape_r[3:2] : fcsr_pkg::XCHG_NONE;
  wire [1:0] dor_sel = dor_r[1:0];

  // id of the selected drive
  wire [1:0] sel_id = drv_id_r[{dor_sel, 1'b0} +: 2];
  // tape readback differs by mode
  wire [7:0] tape_rd = enh_mode ? {fcsr_pkg::TAPE_RSVD, sel_id, tape_r} :
                       {6'h00, tape_r[1:0]};

  // status readback; all zero until initialised
  wire hold_init = ~dor_r[fcsr_pkg::DOR_NRST_BIT] | power_down;
  wire nondma_bit = ready_r & exec_nondma;
  wire dir_bit = ready_r & dir_to_host;
  wire [7:0] main_rd = ready_r ? {rqm_r, dir_bit, nondma_bit, cip_r, busy_r} :
                       fcsr_pkg::MAIN_NOT_READY;

  // read multiplexer; rate-select and rate-control read as zero
  wire [7:0] rd_byte = (s_axi_araddr == fcsr_pkg::OFF_TAPE) ? tape_rd :
                       (s_axi_araddr == fcsr_pkg::OFF_MAIN) ? main_rd :
                       (s_axi_araddr == fcsr_pkg::OFF_DRV_OUT) ? dor_r :
                       (s_axi_araddr == fcsr_pkg::OFF_CFG) ? cfg_r :
                       (s_axi_araddr == fcsr_pkg::OFF_DRV_ID) ? drv_id_r :
                       (s_axi_araddr == fcsr_pkg::OFF_PCMP_TRK) ? pcmp_trk_r :
                       8'h00;
  wire rd_hit = fcsr_hit(s_axi_araddr);

  // ready counter end
  wire ready_set = ~hold_init & ~ready_r & (init_cnt_r == CNT_LAST);

  // busy bits: set wins over clear
  logic [3:0] busy_nxt;
  logic [3:0] drive_sel_nxt;   // physical selects after exchange
  logic [3:0] motor_nxt;       // physical motors after exchange
  genvar g;
  for (g = 0; g < 4; g++) begin : g_drv
    // per-drive busy
    assign busy_nxt[g] = ready_r & ((seek_issue && seek_drive == 2'(g)) |
                         (busy_r[g] & ~(sense_first_rd && sense_drive == 2'(g))));
    // physical outputs follow the mapped logical drive
    assign drive_sel_nxt[g] = (fcsr_map(2'(g), xchg_eff) == dor_sel);
    assign motor_nxt[g] = dor_r[fcsr_pkg::DOR_MOTOR_LSB + int'(fcsr_map(2'(g), xchg_eff))];
  end

  // command in progress: first write sets, end of command clears
  wire cip_clr = result_last_rd | (cmd_last_wr & cmd_no_result);
  wire cip_nxt = ready_r & (cmd_first_wr | (cip_r & ~cip_clr));

  // request for master
  wire rqm_nxt = hold_init ? 1'b0 :
                 !ready_r ? ready_set :
                 exec_nondma ? int_status :
                 ready_next ? 1'b1 :
                 byte_xfer ? 1'b0 : rqm_r;

  // precomp step count from code and active rate
  wire [2:0] pcmp_code = rate_sel_r[4:2];
  wire [2:0] pcmp_def = (rate_act_r == fcsr_pkg::RATE_1M) ?
                        fcsr_pkg::PCMP_DEF_FAST : fcsr_pkg::PCMP_DEF_SLOW;
  wire [2:0] pcmp_nxt = (pcmp_code == fcsr_pkg::PCMP_DEFAULT) ? pcmp_def :
                        (pcmp_code == fcsr_pkg::PCMP_ZERO) ? fcsr_pkg::PCMP_NONE :
                        pcmp_code;

  // axi channel control
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      bvalid_r <= 1'b0;
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
    end else begin
      aw_held_r <= aw_held_nxt;
      w_held_r <= w_held_nxt;
      awready_r <= ~aw_held_nxt;
      wready_r <= ~w_held_nxt;
      bvalid_r <= bvalid_nxt;
      arready_r <= ~rvalid_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  // axi payload capture
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      aw_addr_r <= '0;
      w_data_r <= 8'h00;
      w_lane0_r <= 1'b0;
      bresp_r <= fcsr_pkg::RESP_OKAY;
      rdata_r <= '0;
      rresp_r <= fcsr_pkg::RESP_OKAY;
    end else begin
      if (take_aw) aw_addr_r <= s_axi_awaddr;
      if (take_w) begin
        w_data_r <= s_axi_wdata[7:0];
        w_lane0_r <= s_axi_wstrb[0];
      end
      // unmapped addresses answer slave error
      if (do_wr) bresp_r <= fcsr_hit(aw_addr_r) ? fcsr_pkg::RESP_OKAY : fcsr_pkg::RESP_SLVERR;
      if (take_ar) begin
        rdata_r <= {24'h000000, rd_byte};
        rresp_r <= rd_hit ? fcsr_pkg::RESP_OKAY : fcsr_pkg::RESP_SLVERR;
      end
    end
  end

  // registers cleared only by hardware reset; soft reset leaves them
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tape_r <= fcsr_pkg::TAPE_RST;
      rate_sel_r <= fcsr_pkg::RATE_SEL_RST;
      rate_act_r <= fcsr_pkg::RATE_SEL_RST[1:0];
      dor_r <= fcsr_pkg::DRV_OUT_RST;
      cfg_r <= fcsr_pkg::CFG_RST;
      drv_id_r <= fcsr_pkg::DRV_ID_RST;
      pcmp_trk_r <= fcsr_pkg::PCMP_TRK_RST;
    end else begin
      if (wr_tape) tape_r <= w_data_r[3:0];
      if (wr_rate_sel) rate_sel_r <= w_data_r;
      // one write per time, so the latest of the two rate writes wins
      if (wr_rate_sel || wr_rate_ctl) rate_act_r <= w_data_r[1:0];
      if (wr_dor) dor_r <= w_data_r;
      if (wr_cfg) cfg_r <= w_data_r;
      if (wr_drv_id) drv_id_r <= w_data_r;
      if (wr_pcmp_trk) pcmp_trk_r <= w_data_r;
    end
  end

  // init counter restarts on soft reset or power down
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      init_cnt_r <= '0;
      ready_r <= 1'b0;
    end else if (hold_init) begin
      init_cnt_r <= '0;
      ready_r <= 1'b0;
    end else if (!ready_r) begin
      init_cnt_r <= init_cnt_r + CNT_W'(1);
      ready_r <= ready_set;
    end
  end

  // status flags
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      busy_r <= 4'h0;
      cip_r <= 1'b0;
      rqm_r <= 1'b0;
    end else begin
      busy_r <= busy_nxt;
      cip_r <= cip_nxt;
      rqm_r <= rqm_nxt;
    end
  end

  // drive side outputs
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      drive_sel_r <= 4'h1;
      motor_r <= 4'h0;
      dma_en_r <= 1'b0;
      ctl_reset_r <= 1'b1;
      pcmp_steps_r <= fcsr_pkg::PCMP_DEF_SLOW;
    end else begin
      drive_sel_r <= drive_sel_nxt;
      motor_r <= motor_nxt;
      dma_en_r <= dor_r[fcsr_pkg::DOR_DMA_BIT];
      ctl_reset_r <= hold_init;
      pcmp_steps_r <= pcmp_nxt;
    end
  end

  // port drive
  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign drive_sel = drive_sel_r;
  assign motor_en = motor_r;
  assign dma_en = dma_en_r;
  assign ctl_reset = ctl_reset_r;
  assign data_rate = rate_act_r;
  assign precomp_steps = pcmp_steps_r;
  assign precomp_track = pcmp_trk_r;
  assign tape_drive = tape_r[1:0];

  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  chk_status_zero: assert property (take_ar && s_axi_araddr == fcsr_pkg::OFF_MAIN && !ready_r
    |=> s_axi_rdata == 32'h0)
    else $error("status not zero before ready");
  chk_ready_value: assert property (ready_set |=> ready_r && main_rd[7] && main_rd[4:0] == 5'h00)
    else $error("status not 80h at ready");
  chk_busy_set: assert property (ready_r && seek_issue |=> busy_r[$past(seek_drive)])
    else $error("busy bit not set after seek");
  chk_cip_clear: assert property (ready_r && !cmd_first_wr && result_last_rd |=> !cip_r)
    else $error("command in progress not cleared");
  chk_nondma_bit: assert property (ready_r |-> main_rd[5] == exec_nondma)
    else $error("non-dma bit wrong");
  chk_rqm_clear: assert property (ready_r && !hold_init && byte_xfer && !ready_next
    && !exec_nondma |=> !rqm_r)
    else $error("rqm not cleared after byte");
  chk_rate_latest: assert property (wr_rate_sel || wr_rate_ctl |=> data_rate == $past(w_data_r[1:0]))
    else $error("rate not from latest write");
  chk_precomp_default: assert property (pcmp_code == 3'h0 && rate_act_r == 2'h3 |=>
    precomp_steps == 3'h1)
    else $error("default precomp wrong at 1M");
  chk_one_drive: assert property ($onehot(drive_sel))
    else $error("drive select not one-hot");
  chk_four_noswap: assert property (four_drive && dor_sel == 2'h0 ##1 four_drive && dor_sel == 2'h0
    |-> drive_sel == 4'h1)
    else $error("exchange with four drives");

  cov_ready: cover property (ready_set ##1 rqm_r);
  cov_seek_sense: cover property (seek_issue ##[1:20] sense_first_rd);
  cov_swap02: cover property (xchg_eff == 2'h2 && dor_sel == 2'h0 ##1 drive_sel == 4'h4);
  cov_write_resp: cover property (do_wr ##1 s_axi_bvalid);

endmodule : fcsr_regs

// File: verif/fcsr_host.sv
`timescale 1ns/1ps
// host processor model: at most one axi4-lite write and one read under way
module fcsr_host (
  // clock
  input wire logic ref_clk,
  // write address, data and response
  output logic [fcsr_pkg::ADDR_W-1:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [fcsr_pkg::DATA_W-1:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  // read address and data
  output logic [fcsr_pkg::ADDR_W-1:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [fcsr_pkg::DATA_W-1:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  // bus idle at time zero
  initial begin
    s_axi_awaddr = 8'h00;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'h0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = 8'h00;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
  end

  // write one word: address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr

  // read one word; software polls status this way before each byte
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
endmodule : fcsr_host

// File: verif/test_floppy_ctrl_status_rate_regs.sv
`timescale 1ns/1ps
// register bank bench: host bus calls with expected values
module test_floppy_ctrl_status_rate_regs;
  // clock, reset and bus wires
  logic ref_clk, rst;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_data;
  logic [3:0] s_axi_wstrb, drive_sel, motor_en;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, dma_en, ctl_reset;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp, data_rate, tape_drive, drv;
  logic [2:0] precomp_steps;
  logic [7:0] precomp_track;
  // engine pulses: first_wr, last_wr, last_rd, seek, sense, xfer, ready
  logic [6:0] ev;
  logic cmd_no_result, exec_nondma, dir_to_host, int_status, power_down;
  int fails, check_count, i;

  // short ready count keeps the run brief
  fcsr_regs #(.READY_CYCLES(16)) dut_u (
    .ref_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .cmd_first_wr(ev[0]), .cmd_last_wr(ev[1]),
    .cmd_no_result, .result_last_rd(ev[2]), .seek_issue(ev[3]), .seek_drive(drv),
    .sense_first_rd(ev[4]), .sense_drive(drv), .byte_xfer(ev[5]), .ready_next(ev[6]),
    .exec_nondma, .dir_to_host, .int_status, .power_down, .drive_sel, .motor_en, .dma_en,
    .ctl_reset, .data_rate, .precomp_steps, .precomp_track, .tape_drive
  );

  // host model drives the bus
  fcsr_host host_u (
    .ref_clk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready
  );

  // 40 mhz clock
  always #12.5 ref_clk = ~ref_clk;

  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // write, check response, let outputs settle
  task automatic wreg(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er = fcsr_pkg::RESP_OKAY);
    host_u.wr(a, d, resp);
    chk(32'(resp), 32'(er));
    repeat (2) @(posedge ref_clk);
  endtask : wreg

  // read and compare data and response
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp,
                      input logic [1:0] er = fcsr_pkg::RESP_OKAY);
    host_u.rd(a, rd_data, resp);
    chk(rd_data, exp);
    chk(32'(resp), 32'(er));
  endtask : rchk

  // one-cycle engine pulse, then status read
  task automatic step(input int n, input logic [7:0] exp);
    @(posedge ref_clk);
    ev[n] <= 1'b1;
    @(posedge ref_clk);
    ev <= 7'h00;
    rchk(fcsr_pkg::OFF_MAIN, 32'(exp));
  endtask : step

  // engine levels, then status read
  task automatic lvl(input logic d, input logic e, input logic q, input logic [7:0] exp);
    @(posedge ref_clk);
    dir_to_host <= d;
    exec_nondma <= e;
    int_status <= q;
    rchk(fcsr_pkg::OFF_MAIN, 32'(exp));
  endtask : lvl

  // closing report
  task automatic print_verdict;
    $display("checks=%0d mismatches=%0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : print_verdict

  // watchdog cuts a hang short
  initial begin
    repeat (6000) @(posedge ref_clk);
    fails++;
    print_verdict();
  end

  // main sequence
  initial begin
    ref_clk = 1'b0;
    rst = 1'b1;
    ev = 7'h00;
    drv = 2'h2;
    {cmd_no_result, exec_nondma, dir_to_host, int_status, power_down} = 5'h00;
    fails = 0;
    check_count = 0;
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    // reset values at the ports and over the bus
    chk(32'(drive_sel), 32'h1);
    chk(32'(data_rate), 32'h2);
    chk(32'(precomp_steps), 32'h3);
    chk(32'(precomp_track), 32'h0);
    rchk(fcsr_pkg::OFF_MAIN, 32'h0);
    rchk(fcsr_pkg::OFF_RATE_SEL, 32'h0);
    rchk(8'h20, 32'h0, fcsr_pkg::RESP_SLVERR);
    wreg(8'h20, 32'h1, fcsr_pkg::RESP_SLVERR);
    // leave soft reset, status stays 00h then turns 80h
    wreg(fcsr_pkg::OFF_DRV_OUT, 32'h04);
    rchk(fcsr_pkg::OFF_MAIN, 32'h0);
    repeat (20) @(posedge ref_clk);
    rchk(fcsr_pkg::OFF_MAIN, 32'h80);
    // every rate with default precompensation
    for (i = 0; i < 4; i++) begin
      wreg(fcsr_pkg::OFF_RATE_SEL, 32'(i));
      chk(32'(data_rate), 32'(i));
      chk(32'(precomp_steps), (i == 3) ? 32'h1 : 32'h3);
    end
    // every explicit precompensation code
    for (i = 1; i < 8; i++) begin
      wreg(fcsr_pkg::OFF_RATE_SEL, 32'({i[2:0], 2'b10}));
      chk(32'(precomp_steps), (i == 7) ? 32'h0 : 32'(i));
    end
    // last write to either rate register wins
    wreg(fcsr_pkg::OFF_RATE_CTL, 32'h1);
    chk(32'(data_rate), 32'h1);
    wreg(fcsr_pkg::OFF_RATE_SEL, 32'h0);
    chk(32'(data_rate), 32'h0);
    // tape select codes in enhanced mode
    wreg(fcsr_pkg::OFF_CFG, 32'h40);
    wreg(fcsr_pkg::OFF_DRV_ID, 32'h0e);
    for (i = 0; i < 4; i++) begin
      wreg(fcsr_pkg::OFF_TAPE, 32'(i));
      chk(32'(tape_drive), 32'(i));
    end
    // exchange drives 0 and 1, id of selected drive
    wreg(fcsr_pkg::OFF_TAPE, 32'h05);
    chk(32'(drive_sel), 32'h2);
    rchk(fcsr_pkg::OFF_TAPE, 32'he5);
    wreg(fcsr_pkg::OFF_DRV_OUT, 32'h05);
    chk(32'(drive_sel), 32'h1);
    rchk(fcsr_pkg::OFF_TAPE, 32'hf5);
    // compatible mode hides upper bits and exchange
    wreg(fcsr_pkg::OFF_CFG, 32'h00);
    rchk(fcsr_pkg::OFF_TAPE, 32'h01);
    chk(32'(drive_sel), 32'h2);
    // four-drive setting blocks exchange of 0 and 2
    wreg(fcsr_pkg::OFF_CFG, 32'hc0);
    wreg(fcsr_pkg::OFF_TAPE, 32'h09);
    wreg(fcsr_pkg::OFF_DRV_OUT, 32'h04);
    chk(32'(drive_sel), 32'h1);
    wreg(fcsr_pkg::OFF_CFG, 32'h40);
    chk(32'(drive_sel), 32'h4);
    // motor of logical drive 0 lands on physical drive 2; dma enable follows bit 3
    wreg(fcsr_pkg::OFF_DRV_OUT, 32'h1c);
    chk(32'(motor_en), 32'h4);
    chk(32'(dma_en), 32'h1);
    chk(32'(drive_sel), 32'h4);
    // status bits driven by engine events
    step(0, 8'h90);
    step(5, 8'h10);
    step(6, 8'h90);
    step(3, 8'h94);
    step(4, 8'h90);
    step(2, 8'h80);
    cmd_no_result <= 1'b1;
    step(0, 8'h90);
    step(1, 8'h80);
    lvl(1'b1, 1'b0, 1'b0, 8'hc0);
    lvl(1'b1, 1'b1, 1'b0, 8'h60);
    lvl(1'b1, 1'b1, 1'b1, 8'he0);
    lvl(1'b0, 1'b0, 1'b0, 8'h80);
    // soft reset keeps the rate, status back to 00h
    wreg(fcsr_pkg::OFF_RATE_CTL, 32'h1);
    wreg(fcsr_pkg::OFF_DRV_OUT, 32'h00);
    chk(32'(data_rate), 32'h1);
    chk(32'(ctl_reset), 32'h1);
    rchk(fcsr_pkg::OFF_MAIN, 32'h0);
    // hardware reset in mid-run reloads the rate
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    chk(32'(data_rate), 32'h2);
    chk(32'(tape_drive), 32'h0);
    chk(32'(drive_sel), 32'h1);
    print_verdict();
  end
endmodule : test_floppy_ctrl_status_rate_regs
